// file: rtl/aop_pkg.sv
// Constants and types shared by the converter output port block
package aop_pkg;
  // Register byte offsets
  localparam logic [7:0] AOP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] AOP_STATUS_OFS = 8'h04;
  localparam logic [7:0] AOP_RESULT_OFS = 8'h08;
  localparam logic [2:0] AOP_HSIZE_WORD = 3'h2;
  // Control register fields and reset value
  localparam int AOP_CTRL_W      = 5;
  localparam int AOP_CTRL_SERIAL = 0;
  localparam int AOP_CTRL_SWAP   = 1;
  localparam int AOP_CTRL_BINARY = 2;
  localparam int AOP_CTRL_FAST   = 3;
  localparam int AOP_CTRL_LOWPWR = 4;
  localparam logic [4:0] AOP_CTRL_RESET = 5'h04;
  // Status register fields
  localparam int AOP_ST_MODE    = 0;
  localparam int AOP_ST_SERIAL  = 2;
  localparam int AOP_ST_SLAVE   = 3;
  localparam int AOP_ST_SYNCPOL = 4;
  localparam int AOP_ST_READT   = 5;
  localparam int AOP_ST_DIV     = 6;
  localparam int AOP_ST_FRAME   = 8;
  localparam int AOP_ST_ACCLOST = 9;
  localparam int AOP_ST_IDLE    = 10;
  // Shared data pin positions
  localparam int AOP_PIN_DIV     = 2;
  localparam int AOP_PIN_CLKSRC  = 4;
  localparam int AOP_PIN_SYNCPOL = 5;
  localparam int AOP_PIN_READT   = 7;
  localparam int AOP_PIN_SERIAL_RESULT_OUT   = 8;
  localparam int AOP_PIN_SCLK    = 9;
  localparam int AOP_DATA_W      = 16;
  localparam int AOP_BYTE_W      = 8;
  localparam logic [4:0] AOP_BITS = 5'h10;
  // Timing figures and derived cycle counts
  localparam int AOP_CLK_PERIOD_NS = 10;
  localparam int AOP_SCLK_MIN_NS [4] = '{25, 50, 100, 200};
  localparam int AOP_FAST_MAX_US = 1000;
  localparam int AOP_FAST_MAX_CYC =
    AOP_FAST_MAX_US * 1000 / AOP_CLK_PERIOD_NS;
  // Conversion modes
  typedef enum logic [1:0] {
    AOP_MODE_NORMAL  = 2'h0,
    AOP_MODE_FAST    = 2'h1,
    AOP_MODE_REDUCED = 2'h2
  } aop_mode_type;
  // Serial shifter states
  typedef enum logic [2:0] {
    AOP_SH_IDLE  = 3'h1,
    AOP_SH_LEAD  = 3'h2,
    AOP_SH_SHIFT = 3'h4
  } aop_shift_state_type;
  // Half period of the internal serial clock, rounded up
  function automatic logic [3:0] aopHalfCycles(input logic [1:0] code);
    int ns;
    ns = AOP_SCLK_MIN_NS[code];
    return 4'((ns + 2 * AOP_CLK_PERIOD_NS - 1) / (2 * AOP_CLK_PERIOD_NS));
  endfunction
endpackage

// file: rtl/aop_serial_shifter.sv
// Serial result shifter with internal clock generator and slave path
`timescale 1ns/1ps
`default_nettype none
module aop_serial_shifter
  import aop_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // Master frame control
  input  wire logic                  masterMode,
  input  wire logic                  startFrame,
  input  wire logic [3:0]            halfCycles,
  input  wire logic [AOP_DATA_W-1:0] word,
  // Slave clocking, already synchronised
  input  wire logic                  slaveSelect,
  input  wire logic                  slaveSclk,
  // Serial outputs
  output logic                       serialBit,
  output logic                       sclkLevel,
  output logic                       frameActive
);
  typedef struct packed {
    aop_shift_state_type   state;
    logic [AOP_DATA_W-1:0] shift;
    logic [4:0]            bitsLeft;
    logic [3:0]            timer;
    logic                  sclk;
    logic                  frame;
    logic                  selPrev;
    logic                  sclkPrev;
  } aop_shifter_type;
  localparam aop_shifter_type SH_RESET = '{state: AOP_SH_IDLE, default: '0};
  aop_shifter_type st;
  aop_shifter_type next_st;

  // Frame sequencing; data changes on internal clock falling edges and on rising slave clock edges
  always_comb begin
    next_st = st;
    next_st.selPrev  = slaveSelect;
    next_st.sclkPrev = slaveSclk;
    case (st.state)
      AOP_SH_IDLE: begin
        next_st.sclk  = 1'b0;
        next_st.frame = 1'b0;
        if (masterMode && startFrame) begin
          next_st.shift = word;
          next_st.frame = 1'b1;
          next_st.timer = halfCycles;
          next_st.state = AOP_SH_LEAD;
        end else if (!masterMode && slaveSelect && !st.selPrev) begin
          next_st.shift = word; // MSB out at select
        end else if (!masterMode && slaveSelect && slaveSclk &&
                     !st.sclkPrev) begin
          next_st.shift = {st.shift[AOP_DATA_W-2:0], 1'b0};
        end
      end
      AOP_SH_LEAD: begin
        next_st.timer = st.timer - 4'h1;
        if (st.timer == 4'h1) begin
          next_st.timer    = halfCycles;
          next_st.sclk     = 1'b1;
          next_st.bitsLeft = AOP_BITS;
          next_st.state    = AOP_SH_SHIFT;
        end
      end
      AOP_SH_SHIFT: begin
        next_st.timer = st.timer - 4'h1;
        if (st.timer == 4'h1) begin
          next_st.timer = halfCycles;
          next_st.sclk  = !st.sclk;
          if (st.sclk) begin
            next_st.shift    = {st.shift[AOP_DATA_W-2:0], 1'b0};
            next_st.bitsLeft = st.bitsLeft - 5'h01;
            if (st.bitsLeft == 5'h01) begin
              next_st.frame = 1'b0;
              next_st.state = AOP_SH_IDLE;
            end
          end
        end
      end
      default: next_st = SH_RESET;
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= SH_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign serialBit   = st.shift[AOP_DATA_W-1];
  assign sclkLevel   = st.sclk;
  assign frameActive = st.frame;

  // The high clock phase lasts at least two cycles
  a_sclk_half_period: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(st.sclk) |-> st.sclk ##1 st.sclk)
    else $error("internal serial clock high phase too short");

  a_master_frame_start: assert property (
    @(posedge clock) disable iff (sys_rst)
    masterMode && startFrame && st.state == AOP_SH_IDLE
      |=> st.frame && !st.sclk ##[1:10] st.sclk)
    else $error("master frame did not start its clock");
endmodule // aop_serial_shifter
`default_nettype wire

// file: rtl/aop_output_port_config.sv
// Output port configuration and pin sharing for a sampling converter
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module aop_output_port_config
  import aop_pkg::*;
#(
  parameter int unsigned FAST_MAX_CYCLES = AOP_FAST_MAX_CYC
)(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Converter core
  input  wire logic                  convBusy,
  input  wire logic                  resultValid,
  input  wire logic [AOP_DATA_W-1:0] resultIn,
  output aop_mode_type               convMode,
  output logic                       lowPowerIdle,
  // Shared data bus pins
  input  wire logic [AOP_DATA_W-1:0] dataPinIn,
  output logic [AOP_DATA_W-1:0]      dataPinOut,
  output logic [AOP_DATA_W-1:0]      dataPinOe,
  // Chip select and frame sync pins
  input  wire logic                  chipSelectN,
  output logic                       frameSyncOut,
  output logic                       frameSyncOe
);
  localparam logic [19:0] FAST_LIMIT = 20'(FAST_MAX_CYCLES);

  typedef struct packed {
    logic [AOP_CTRL_W-1:0] ctrl;
    logic                  wrCtrl;
    logic                  wrStatus;
    logic [31:0]           rdata;
    logic [AOP_DATA_W-1:0] result;
    logic [7:2]            pinA;
    logic [7:2]            pinB;
    logic                  sclkA;
    logic                  sclkB;
    logic                  csA;
    logic                  csB;
    logic                  busyPrev;
    logic [19:0]           interval;
    logic                  accLost;
    aop_mode_type          mode;
    logic                  idleLow;
    logic [AOP_DATA_W-1:0] pinOut;
    logic [AOP_DATA_W-1:0] pinOe;
    logic                  syncOut;
    logic                  syncOe;
  } aop_port_state_type;

  // Chip select idles high so slave logic starts deselected
  localparam aop_port_state_type ST_RESET = '{
    ctrl:    AOP_CTRL_RESET,
    csA:     1'b1,
    csB:     1'b1,
    mode:    AOP_MODE_NORMAL,
    default: '0
  };

  aop_port_state_type st;
  aop_port_state_type next_st;

  // Output coding: straight binary or MSB inverted
  function automatic logic [AOP_DATA_W-1:0] aopFormat(
    input logic [AOP_DATA_W-1:0] raw,
    input logic                  binary
  );
    logic [AOP_DATA_W-1:0] coded;
    coded = raw;
    coded[AOP_DATA_W-1] = binary ? raw[AOP_DATA_W-1] :
                                   !raw[AOP_DATA_W-1];
    return coded;
  endfunction

  // Byte placement on the parallel bus
  function automatic logic [AOP_DATA_W-1:0] aopSwap(
    input logic [AOP_DATA_W-1:0] word,
    input logic                  swap
  );
    return swap ? {word[AOP_BYTE_W-1:0], word[AOP_DATA_W-1:AOP_BYTE_W]} :
                  word;
  endfunction

  // Conversion mode from the two select bits
  function automatic aop_mode_type aopModeDecode(
    input logic fast,
    input logic lowPower
  );
    if (fast && !lowPower) begin
      return AOP_MODE_FAST;
    end else if (lowPower && !fast) begin
      return AOP_MODE_REDUCED;
    end
    return AOP_MODE_NORMAL;
  endfunction

  // Effective serial configuration from synchronised pins
  logic                  serialMode;
  logic                  slaveClk;
  logic                  syncPol;
  logic                  readTiming;
  logic                  masterRac;
  logic                  masterRdc;
  logic                  csActive;
  logic [1:0]            divCode;
  logic                  startFrame;
  logic [AOP_DATA_W-1:0] shiftWord;
  logic                  shBit;
  logic                  shSclk;
  logic                  shFrame;
  logic                  addrTaken;
  logic [31:0]           statusWord;

  always_comb begin
    serialMode = st.ctrl[AOP_CTRL_SERIAL];
    slaveClk   = st.pinB[AOP_PIN_CLKSRC];
    syncPol    = st.pinB[AOP_PIN_SYNCPOL];
    readTiming = st.pinB[AOP_PIN_READT];
    csActive   = !st.csB;
    masterRac  = serialMode && !slaveClk && !readTiming;
    masterRdc  = serialMode && !slaveClk && readTiming;
    // Divider pins only count in master read-after-convert
    divCode = masterRac ? st.pinB[AOP_PIN_DIV+1:AOP_PIN_DIV] : 2'h0;
    // Frame start: during conversion or once it is done
    startFrame = masterRdc ? (convBusy && !st.busyPrev) :
                 (masterRac && resultValid);
    // After-convert frames carry the fresh result
    shiftWord = masterRac ? aopFormat(resultIn, st.ctrl[AOP_CTRL_BINARY]) :
                            st.result;
  end

  // Status word as seen by software
  always_comb begin
    statusWord = '0;
    statusWord[AOP_ST_MODE+:2]    = st.mode;
    statusWord[AOP_ST_SERIAL]     = serialMode;
    statusWord[AOP_ST_SLAVE]      = slaveClk;
    statusWord[AOP_ST_SYNCPOL]    = syncPol;
    statusWord[AOP_ST_READT]      = readTiming;
    statusWord[AOP_ST_DIV+:2]     = divCode;
    statusWord[AOP_ST_FRAME]      = shFrame;
    statusWord[AOP_ST_ACCLOST]    = st.accLost;
    statusWord[AOP_ST_IDLE]       = st.idleLow;
  end

  assign addrTaken = hsel && hready && htrans[1];

  // Next state of the whole port
  always_comb begin
    next_st = st;
    // Pin synchronisers; first stage feeds only the second
    next_st.pinA  = dataPinIn[AOP_PIN_READT:AOP_PIN_DIV];
    next_st.pinB  = st.pinA;
    next_st.sclkA = dataPinIn[AOP_PIN_SCLK];
    next_st.sclkB = st.sclkA;
    next_st.csA   = chipSelectN;
    next_st.csB   = st.csA;
    next_st.busyPrev = convBusy;

    // Bus address phase; only whole-word writes are taken
    next_st.wrCtrl   = addrTaken && hwrite && hsize == AOP_HSIZE_WORD &&
                       haddr[7:0] == AOP_CTRL_OFS;
    next_st.wrStatus = addrTaken && hwrite && hsize == AOP_HSIZE_WORD &&
                       haddr[7:0] == AOP_STATUS_OFS;
    if (addrTaken && !hwrite) begin
      case (haddr[7:0])
        AOP_CTRL_OFS:   next_st.rdata = 32'(st.ctrl);
        AOP_STATUS_OFS: next_st.rdata = statusWord;
        AOP_RESULT_OFS: next_st.rdata = 32'(st.result);
        default:        next_st.rdata = '0;
      endcase
    end
    // Bus data phase
    if (st.wrCtrl) begin
      next_st.ctrl = hwdata[AOP_CTRL_W-1:0];
    end

    // Result capture in the selected code
    if (resultValid) begin
      next_st.result = aopFormat(resultIn, st.ctrl[AOP_CTRL_BINARY]);
    end

    // Mode selection for the converter core
    next_st.mode = aopModeDecode(st.ctrl[AOP_CTRL_FAST],
                                 st.ctrl[AOP_CTRL_LOWPWR]);
    // Power scales with rate: idle the core between conversions in reduced mode only
    next_st.idleLow = st.mode == AOP_MODE_REDUCED && !convBusy;

    // Rate watchdog; clear first so a same-cycle set wins
    if (st.wrStatus && hwdata[AOP_ST_ACCLOST]) begin
      next_st.accLost = 1'b0;
    end
    if (st.mode == AOP_MODE_FAST && !resultValid) begin
      if (st.interval == FAST_LIMIT) begin
        next_st.accLost = 1'b1;
      end else begin
        next_st.interval = st.interval + 20'h1;
      end
    end else begin
      next_st.interval = '0;
    end

    // Parallel bus: every data pin driven
    next_st.pinOut = aopSwap(st.result, st.ctrl[AOP_CTRL_SWAP]);
    next_st.pinOe  = '1;
    if (serialMode) begin
      // Select pins become inputs, low bits float
      next_st.pinOut = '0;
      next_st.pinOe  = '0;
      next_st.pinOut[AOP_PIN_SERIAL_RESULT_OUT] = shBit;
      next_st.pinOut[AOP_PIN_SCLK]  = shSclk;
      // Slave output floats while deselected
      next_st.pinOe[AOP_PIN_SERIAL_RESULT_OUT] = !slaveClk || csActive;
      next_st.pinOe[AOP_PIN_SCLK]  = !slaveClk;
    end
    next_st.syncOut = shFrame ^ syncPol;
    next_st.syncOe  = serialMode && !slaveClk;
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Serial shifter; slave edges come through the synchroniser
  aop_serial_shifter u_shifter (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .masterMode  (serialMode && !slaveClk),
    .startFrame  (startFrame),
    .halfCycles  (aopHalfCycles(divCode)),
    .word        (shiftWord),
    .slaveSelect (serialMode && slaveClk && csActive),
    .slaveSclk   (st.sclkB),
    .serialBit   (shBit),
    .sclkLevel   (shSclk),
    .frameActive (shFrame)
  );

  // Outputs; zero wait states, always OKAY
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = st.rdata;
  assign convMode     = st.mode;
  assign lowPowerIdle = st.idleLow;
  assign dataPinOut   = st.pinOut;
  assign dataPinOe    = st.pinOe;
  assign frameSyncOut = st.syncOut;
  assign frameSyncOe  = st.syncOe;

  // Parallel word appears two edges after capture
  a_byte_order_low: assert property (
    @(posedge clock) disable iff (sys_rst)
    resultValid && !serialMode && !st.ctrl[AOP_CTRL_SWAP] &&
    st.ctrl[AOP_CTRL_BINARY] && !st.wrCtrl
      |-> ##2 dataPinOut == $past(resultIn, 2))
    else $error("parallel word not in natural byte order");

  a_byte_order_swap: assert property (
    @(posedge clock) disable iff (sys_rst)
    resultValid && !serialMode && st.ctrl[AOP_CTRL_SWAP] &&
    st.ctrl[AOP_CTRL_BINARY] && !st.wrCtrl
      |-> ##2 {dataPinOut[AOP_BYTE_W-1:0],
               dataPinOut[AOP_DATA_W-1:AOP_BYTE_W]} == $past(resultIn, 2))
    else $error("parallel bytes not swapped");

  a_code_twos: assert property (
    @(posedge clock) disable iff (sys_rst)
    resultValid && !st.ctrl[AOP_CTRL_BINARY]
      |=> (st.result ^ {1'b1, {(AOP_DATA_W-1){1'b0}}}) == $past(resultIn))
    else $error("twos complement MSB not inverted");

  a_mode_fast: assert property (
    @(posedge clock) disable iff (sys_rst)
    st.ctrl[AOP_CTRL_FAST] && !st.ctrl[AOP_CTRL_LOWPWR] && !st.wrCtrl
      |=> convMode == AOP_MODE_FAST)
    else $error("fast mode not selected");

  a_no_watchdog: assert property (
    @(posedge clock) disable iff (sys_rst)
    !st.ctrl[AOP_CTRL_FAST] && !st.accLost && !st.wrCtrl
      |=> ##1 !st.accLost && st.interval == '0)
    else $error("rate watchdog ran outside fast mode");

  a_reduced_idle: assert property (
    @(posedge clock) disable iff (sys_rst)
    convMode == AOP_MODE_REDUCED && !convBusy |=> lowPowerIdle)
    else $error("reduced power idle not raised");

  a_parallel_drive: assert property (
    @(posedge clock) disable iff (sys_rst)
    !serialMode && !st.wrCtrl |=> dataPinOe == '1)
    else $error("parallel bus not fully driven");

  a_low_pins_float: assert property (
    @(posedge clock) disable iff (sys_rst)
    serialMode && !st.wrCtrl |=> dataPinOe[1:0] == 2'h0 &&
      dataPinOe[AOP_PIN_DIV+1:AOP_PIN_DIV] == 2'h0)
    else $error("serial mode drives low data or divider pins");

  a_master_clock: assert property (
    @(posedge clock) disable iff (sys_rst)
    serialMode && !slaveClk && !st.wrCtrl |=> dataPinOe[AOP_PIN_SCLK])
    else $error("master serial clock not driven");

  a_slave_gated: assert property (
    @(posedge clock) disable iff (sys_rst)
    serialMode && slaveClk && !csActive && !st.wrCtrl
      |=> !dataPinOe[AOP_PIN_SERIAL_RESULT_OUT] && !dataPinOe[AOP_PIN_SCLK])
    else $error("deselected slave drives serial pins");

  a_sync_polarity: assert property (
    @(posedge clock) disable iff (sys_rst)
    frameSyncOe |-> frameSyncOut == ($past(shFrame) ^ $past(syncPol)))
    else $error("frame sync polarity wrong");

  a_read_during: assert property (
    @(posedge clock) disable iff (sys_rst)
    masterRdc && convBusy && !st.busyPrev && !shFrame |=> shFrame)
    else $error("read during convert frame missing");

  a_read_after: assert property (
    @(posedge clock) disable iff (sys_rst)
    masterRac && resultValid && !shFrame |=> shFrame)
    else $error("read after convert frame missing");
endmodule // aop_output_port_config
`default_nettype wire

// file: testbench/aop_host_model.sv
// Host side model: drives serial select pins and captures serial words
`timescale 1ns/1ps
`default_nettype none
module aop_host_model
  import aop_pkg::*;
(
  // Clock
  input  wire logic                  clock,
  // Device pins
  input  wire logic [AOP_DATA_W-1:0] dataPinOut,
  input  wire logic [AOP_DATA_W-1:0] dataPinOe,
  input  wire logic                  frameSyncOut,
  output logic [AOP_DATA_W-1:0]      dataPinIn,
  // Host settings
  input  wire logic                  readTiming,
  input  wire logic                  clkSrc,
  input  wire logic                  syncPol,
  input  wire logic [1:0]            div,
  // Captured serial data
  output logic [15:0]                rxWord,
  output logic [4:0]                 rxCount
);
  localparam logic [15:0] HOST_MASK = 16'h02bc;
  logic [15:0] hostVal;
  logic        prevSclk;
  // Host holds these selects steady between transfers
  assign hostVal = {8'h00, readTiming, 1'b0, syncPol, clkSrc,
                    div, 2'b00};
  // Wire level; released host mask pins carry the host settings, other released pins the inverse of the device value
  assign dataPinIn = (dataPinOut & dataPinOe)
                   | (hostVal & ~dataPinOe & HOST_MASK)
                   | (~dataPinOut & ~dataPinOe & ~HOST_MASK);
  // Shift in on rising serial clock while the frame is active
  initial begin
    rxWord = 16'h0000;
    rxCount = 5'h00;
    prevSclk = 1'b0;
  end
  always @(posedge clock) begin
    prevSclk <= dataPinOut[AOP_PIN_SCLK];
    if (!prevSclk && dataPinOut[AOP_PIN_SCLK] && (frameSyncOut ^ syncPol)) begin
      rxWord <= {rxWord[14:0], dataPinOut[AOP_PIN_SERIAL_RESULT_OUT]};
      rxCount <= rxCount + 5'h01;
    end
  end
endmodule // aop_host_model
`default_nettype wire

// file: testbench/tb_top.sv
// Testbench for the converter output port configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import aop_pkg::*;
;
  logic clock, sys_rst, hsel, hwrite, hreadyout, hresp, lowPowerIdle;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, div;
  logic [2:0] hsize;
  logic convBusy, resultValid, chipSelectN, frameSyncOut, frameSyncOe;
  logic readTiming, clkSrc, syncPol;
  logic [15:0] resultIn, dataPinIn, dataPinOut, dataPinOe, rxWord;
  logic [4:0] rxCount;
  aop_mode_type convMode;
  int errors, cmp_count, n;
  aop_output_port_config #(.FAST_MAX_CYCLES(50)) dut (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .convBusy(convBusy), .resultValid(resultValid),
    .resultIn(resultIn), .convMode(convMode), .lowPowerIdle(lowPowerIdle),
    .dataPinIn(dataPinIn), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
    .chipSelectN(chipSelectN), .frameSyncOut(frameSyncOut),
    .frameSyncOe(frameSyncOe));
  aop_host_model host (
    .clock(clock), .dataPinOut(dataPinOut), .dataPinOe(dataPinOe),
    .frameSyncOut(frameSyncOut), .dataPinIn(dataPinIn),
    .readTiming(readTiming), .clkSrc(clkSrc), .syncPol(syncPol), .div(div),
    .rxWord(rxWord), .rxCount(rxCount));
  // Clock source
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One single AHB-Lite transfer; waits on hready in both phases
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= AOP_HSIZE_WORD;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  // Result pulse, then let the pin pipeline settle
  task automatic pulse(input logic [15:0] v);
    resultIn <= v;
    resultValid <= 1'b1;
    @(posedge clock);
    resultValid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    results();
  end
  // Main sequence
  initial begin
    errors = 0; cmp_count = 0; sys_rst = 1'b1; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    convBusy = 1'b0; resultValid = 1'b0; resultIn = 16'h0;
    chipSelectN = 1'b1; readTiming = 1'b0; clkSrc = 1'b0; syncPol = 1'b0;
    div = 2'h1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    bus(AOP_CTRL_OFS, 1'b0, 32'h0);
    check(rd, 32'h00000004);
    bus(8'h3c, 1'b0, 32'h0);
    check(rd, 32'h0);
    // Parallel, straight binary, no swap
    pulse(16'h8001);
    check(dataPinOe, 16'hffff);
    check({hresp, hreadyout}, 2'h1);
    check(dataPinOut, 16'h8001);
    bus(AOP_RESULT_OFS, 1'b0, 32'h0);
    check(rd, 32'h00008001);
    // Twos complement with byte swap
    bus(AOP_CTRL_OFS, 1'b1, 32'h2);
    pulse(16'h8001);
    check(dataPinOut, 16'h0100);
    // Conversion modes; fast mode left idle past the rate limit
    bus(AOP_CTRL_OFS, 1'b1, 32'hc);
    repeat (60) @(posedge clock);
    check(convMode, AOP_MODE_FAST);
    bus(AOP_STATUS_OFS, 1'b0, 32'h0);
    check(rd & 32'h00000203, 32'h00000201);
    bus(AOP_CTRL_OFS, 1'b1, 32'h14);
    repeat (3) @(posedge clock);
    check({convMode, lowPowerIdle}, {AOP_MODE_REDUCED, 1'b1});
    bus(AOP_CTRL_OFS, 1'b1, 32'h4);
    repeat (3) @(posedge clock);
    check(convMode, AOP_MODE_NORMAL);
    // Clear the lost flag; it must stay clear outside fast mode
    bus(AOP_STATUS_OFS, 1'b1, 32'h200);
    repeat (3) @(posedge clock);
    bus(AOP_STATUS_OFS, 1'b0, 32'h0);
    check(rd & 32'h00000203, 32'h00000000);
    // Serial master, read after conversion
    bus(AOP_CTRL_OFS, 1'b1, 32'h5);
    repeat (8) @(posedge clock);
    check(dataPinOe[3:0], 4'h0);
    check({dataPinOe[9:8], frameSyncOe, frameSyncOut}, 4'he);
    pulse(16'ha5c3);
    n = 0;
    while (frameSyncOut !== 1'b1 && n < 300) begin @(posedge clock); n++; end
    while (frameSyncOut !== 1'b0 && n < 300) begin @(posedge clock); n++; end
    check({rxCount, rxWord}, {5'h10, 16'ha5c3});
    // Inverted sync, read during conversion, then slave clocking
    syncPol <= 1'b1;
    readTiming <= 1'b1;
    repeat (8) @(posedge clock);
    check({frameSyncOut, dataPinOe[3:2]}, 3'h4);
    // Conversion start sends the previous result, sync active low
    convBusy <= 1'b1;
    @(posedge clock);
    convBusy <= 1'b0;
    n = 0;
    while (frameSyncOut !== 1'b0 && n < 300) begin @(posedge clock); n++; end
    while (frameSyncOut !== 1'b1 && n < 300) begin @(posedge clock); n++; end
    check({rxCount, rxWord}, {5'h00, 16'ha5c3});
    clkSrc <= 1'b1;
    repeat (8) @(posedge clock);
    check({frameSyncOe, dataPinOe[9]}, 2'h0);
    results();
  end
endmodule // tb_top
`default_nettype wire
